// ===== srh_ctrl.sv
// Host controller driving an asynchronous static memory with common data pins
`timescale 1ns/1ns
module srh_ctrl #(
  parameter int unsigned DATA_W = 16  // 16 or 8 bit organisation
) (
  // Clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rstn_i,
  // Request port
  input  wire logic               req_valid_i,
  output logic                    req_ready_o,
  input  wire srh_pkg::srh_req_t  req_i,
  // Answer port
  output logic                    resp_valid_o,
  output logic [srh_pkg::DQ_W-1:0] rdata_o,
  // Memory pins
  output srh_pkg::srh_pins_t      pins_o,
  input  wire logic [srh_pkg::DQ_W-1:0] dq_i
);

  // ==========================================================================
  // Elaboration check
  // ==========================================================================
  if (DATA_W != 8 && DATA_W != 16) begin : g_bad_width
    $error("DATA_W must be 8 or 16");
  end

  localparam logic [srh_pkg::DQ_W-1:0] LANE_MASK =
    (DATA_W == 16) ? 16'hffff : 16'h00ff;
  localparam logic [srh_pkg::CNT_W-1:0] AS_END =
    srh_pkg::CNT_W'(srh_pkg::AS_CYC - 1);
  localparam logic [srh_pkg::CNT_W-1:0] WP_END =
    srh_pkg::CNT_W'(srh_pkg::WP_CYC - 1);
  localparam logic [srh_pkg::CNT_W-1:0] WP1_END =
    srh_pkg::CNT_W'(srh_pkg::WP1_CYC - 1);
  localparam logic [srh_pkg::CNT_W-1:0] WR_END =
    srh_pkg::CNT_W'(srh_pkg::WR_CYC - 1);
  localparam logic [srh_pkg::CNT_W-1:0] RD_END =
    srh_pkg::CNT_W'(srh_pkg::RD_CYC - 1);
  localparam logic [srh_pkg::CNT_W-1:0] HZ_END =
    srh_pkg::CNT_W'(srh_pkg::HZ_CYC - 1);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    srh_pkg::srh_state_t         state;  // Sequencer
    logic [srh_pkg::CNT_W-1:0]   cnt;    // Cycles within a phase
    logic                        resp;   // Answer pulse
    logic [srh_pkg::DQ_W-1:0]    rdata;  // Captured read data
    srh_pkg::srh_pins_t          pins;   // Registered pin levels
  } srh_ctrl_st_t;

  srh_ctrl_st_t st_reg;   // Current state
  srh_ctrl_st_t st_next;  // Next state
  logic [srh_pkg::DQ_W-1:0] dq_sync;  // Retimed data pins

  // Strobe levels for a request, disabled lanes stay high, and both stay high in x8 mode
  function automatic logic [1:0] lane_strobes_n(input logic [1:0] be);
    if (DATA_W == 16) begin
      return ~be;
    end
    return 2'b11;
  endfunction

  // Pins parked: deselected, nothing driven
  function automatic srh_pkg::srh_pins_t pins_park(
    input srh_pkg::srh_pins_t p);
    srh_pkg::srh_pins_t q;
    q = p;
    q.cs_n = srh_pkg::PIN_IDLE_N;
    q.we_n = srh_pkg::PIN_IDLE_N;
    q.oe_n = srh_pkg::PIN_IDLE_N;
    q.upper_byte_strobe_n = srh_pkg::PIN_IDLE_N;
    q.lower_byte_strobe_n = srh_pkg::PIN_IDLE_N;
    q.dq_oe = '0;
    return q;
  endfunction

  // ==========================================================================
  // Read data synchroniser
  // ==========================================================================
  srh_sync #(
    .WIDTH (srh_pkg::DQ_W)
  ) u_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .d_i    (dq_i),
    .q_o    (dq_sync)
  );

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Next state; pins only change as whole phases so no glitch reaches them
  always_comb begin
    st_next      = st_reg;
    st_next.resp = 1'b0;
    st_next.cnt  = st_reg.cnt + 1'b1;
    case (st_reg.state)
      srh_pkg::ST_IDLE: begin
        st_next.cnt = '0;
        if (req_valid_i) begin
          // Address set as select falls, never address late
          st_next.pins.addr = req_i.addr;
          st_next.pins.dq   = req_i.wdata & LANE_MASK;
          st_next.pins.cs_n = 1'b0;
          st_next.pins.we_n = 1'b1;
          {st_next.pins.upper_byte_strobe_n,
           st_next.pins.lower_byte_strobe_n} = lane_strobes_n(req_i.be);
          if (req_i.we) begin
            // Gate kept high during writes: shorter pulse, no fight
            st_next.pins.oe_n = 1'b1;
            st_next.state     = srh_pkg::ST_WR_SETUP;
          end else begin
            st_next.pins.oe_n = 1'b0;
            st_next.state     = srh_pkg::ST_RD_ACC;
          end
        end
      end
      srh_pkg::ST_WR_SETUP: begin
        // Select already low, so the strobe fall starts the write
        if (st_reg.cnt == AS_END) begin
          st_next.pins.we_n  = 1'b0;
          st_next.pins.dq_oe = LANE_MASK & ~(st_reg.pins.oe_n ? 16'h0000
                                                               : 16'hffff);
          st_next.cnt        = '0;
          st_next.state      = srh_pkg::ST_WR_PULSE;
        end
      end
      srh_pkg::ST_WR_PULSE: begin
        // Pulse length follows the output gate level
        if (st_reg.cnt == (st_reg.pins.oe_n ? WP_END : WP1_END)) begin
          st_next.pins.we_n = 1'b1;
          st_next.cnt       = '0;
          st_next.state     = srh_pkg::ST_WR_RECOV;
        end
      end
      srh_pkg::ST_WR_RECOV: begin
        // Address and data held until recovery is over
        if (st_reg.cnt == WR_END) begin
          st_next.pins  = pins_park(st_reg.pins);
          st_next.resp  = 1'b1;
          st_next.cnt   = '0;
          st_next.state = srh_pkg::ST_IDLE;
        end
      end
      srh_pkg::ST_RD_ACC: begin
        // Capture after access plus retiming delay
        if (st_reg.cnt == RD_END) begin
          st_next.rdata = dq_sync & LANE_MASK;
          st_next.pins  = pins_park(st_reg.pins);
          st_next.resp  = 1'b1;
          st_next.cnt   = '0;
          st_next.state = srh_pkg::ST_RD_TURN;
        end
      end
      srh_pkg::ST_RD_TURN: begin
        // Let the memory release the bus before anyone drives it
        if (st_reg.cnt == HZ_END) begin
          st_next.cnt   = '0;
          st_next.state = srh_pkg::ST_IDLE;
        end
      end
      default: begin
        st_next.pins  = pins_park(st_reg.pins);
        st_next.cnt   = '0;
        st_next.state = srh_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg            <= '0;
      st_reg.state      <= srh_pkg::ST_IDLE;
      st_reg.pins.cs_n  <= srh_pkg::PIN_IDLE_N;
      st_reg.pins.we_n  <= srh_pkg::PIN_IDLE_N;
      st_reg.pins.oe_n  <= srh_pkg::PIN_IDLE_N;
      st_reg.pins.upper_byte_strobe_n <= srh_pkg::PIN_IDLE_N;
      st_reg.pins.lower_byte_strobe_n <= srh_pkg::PIN_IDLE_N;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign req_ready_o  = (st_reg.state == srh_pkg::ST_IDLE);
  assign resp_valid_o = st_reg.resp;
  assign rdata_o      = st_reg.rdata;
  assign pins_o       = st_reg.pins;

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [srh_pkg::CNT_W:0] wp_len;  // Low time of the write strobe

  // Measure write strobe low time
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_len <= '0;
    end else if (!pins_o.we_n) begin
      wp_len <= wp_len + 1'b1;
    end else begin
      wp_len <= '0;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_write_needs_sel: assert property (
    !pins_o.we_n |-> !pins_o.cs_n)
    else $error("write strobe low while deselected");
  a_sel_before_we: assert property (
    $fell(pins_o.we_n) |-> $past(!pins_o.cs_n))
    else $error("select did not precede write strobe");
  a_read_we_high: assert property (
    !pins_o.oe_n && !pins_o.cs_n |-> pins_o.we_n)
    else $error("write strobe low during read");
  // Data stays driven one cycle past the strobe rise as write hold
  a_no_contention: assert property (
    (|pins_o.dq_oe) |-> pins_o.oe_n && !pins_o.cs_n)
    else $error("data driven outside a selected write");
  // Counter already holds the full low time at the rise
  a_pulse_width: assert property (
    $rose(pins_o.we_n) |-> wp_len >=
      (pins_o.oe_n ? srh_pkg::WP_CYC : srh_pkg::WP1_CYC))
    else $error("write pulse too short");
  a_end_by_strobe: assert property (
    $rose(pins_o.we_n) |-> !pins_o.cs_n ##1 $stable(pins_o.addr))
    else $error("write ended without recovery");
  a_addr_stable: assert property (
    !pins_o.cs_n && !$fell(pins_o.cs_n) |-> $stable(pins_o.addr))
    else $error("address moved while selected");
  a_read_latency: assert property (
    $fell(pins_o.oe_n) |-> ##5 resp_valid_o && pins_o.oe_n)
    else $error("read answer not on time");
  a_byte_x8: assert property (
    DATA_W == 8 |-> pins_o.upper_byte_strobe_n &&
                    pins_o.lower_byte_strobe_n)
    else $error("byte strobe active in x8 mode");
  a_turnaround: assert property (
    $rose(pins_o.oe_n) |-> !req_ready_o)
    else $error("no bus turnaround after read");

  c_write: cover property ($rose(pins_o.we_n));
  c_read: cover property ($fell(pins_o.oe_n) ##5 resp_valid_o);
  c_upper_only: cover property (!pins_o.we_n &&
    pins_o.lower_byte_strobe_n && !pins_o.upper_byte_strobe_n);
  c_back_to_back: cover property (resp_valid_o ##[1:3]
    (req_valid_i && req_ready_o));

endmodule

// ===== srh_pkg.sv
// Shared constants and carrier types for the static memory host controller
package srh_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned ADDR_W = 22;  // Enough for the x8 organisation
  localparam int unsigned DQ_W   = 16;  // Widest data organisation
  localparam int unsigned BE_W   = 2;   // One strobe per byte lane
  localparam int unsigned CNT_W  = 3;   // Phase counter width
  localparam int unsigned SYNC_STAGES = 2;  // Flops on the data input pins

  // ==========================================================================
  // Timing, in picoseconds as printed, and derived cycle counts
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 8000;   // 125 MHz clock
  localparam int unsigned T_AS_PS       = 1500;   // Address setup
  localparam int unsigned T_WP_PS       = 7000;   // Pulse with gate high
  localparam int unsigned T_WP1_PS      = 10000;  // write_pulse_gate_low
  localparam int unsigned T_WR_PS       = 1500;   // write_recovery_time
  localparam int unsigned T_AA_PS       = 10000;  // Address access
  localparam int unsigned T_HZ_PS       = 5000;   // Output release

  // Least time to whole cycles, never below one
  function automatic int unsigned min_cycles(input int unsigned ps);
    int unsigned c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned AS_CYC  = min_cycles(T_AS_PS);
  localparam int unsigned WP_CYC  = min_cycles(T_WP_PS);
  localparam int unsigned WP1_CYC = min_cycles(T_WP1_PS);
  localparam int unsigned WR_CYC  = min_cycles(T_WR_PS);
  localparam int unsigned AA_CYC  = min_cycles(T_AA_PS);
  localparam int unsigned HZ_CYC  = min_cycles(T_HZ_PS);
  // Access plus synchroniser delay plus one cycle of margin
  localparam int unsigned RD_CYC  = AA_CYC + SYNC_STAGES + 1;

  // ==========================================================================
  // Reset values of the pins (everything deselected)
  // ==========================================================================
  localparam logic PIN_IDLE_N = 1'b1;

  // ==========================================================================
  // Types
  // ==========================================================================
  // Controller states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_WR_SETUP = 6'h02,
    ST_WR_PULSE = 6'h04,
    ST_WR_RECOV = 6'h08,
    ST_RD_ACC   = 6'h10,
    ST_RD_TURN  = 6'h20
  } srh_state_t;

  // User request
  typedef struct packed {
    logic              we;      // 1 = write, 0 = read
    logic [ADDR_W-1:0] addr;    // Word address
    logic [DQ_W-1:0]   wdata;   // Write data
    logic [BE_W-1:0]   be;      // Byte enables, bit 0 = low lane
  } srh_req_t;

  // Pins driven towards the memory
  typedef struct packed {
    logic              cs_n;                 // Chip select
    logic              we_n;                 // Write strobe
    logic              oe_n;                 // Output gate
    logic              upper_byte_strobe_n;  // Lane 8..15
    logic              lower_byte_strobe_n;  // Lane 0..7
    logic [ADDR_W-1:0] addr;                 // Address pins
    logic [DQ_W-1:0]   dq;                   // Data out
    logic [DQ_W-1:0]   dq_oe;                // Data drive enable
  } srh_pins_t;

endpackage

// ===== srh_sync.sv
// Two-flop synchroniser for the data pins read back from the memory
`timescale 1ns/1ns
module srh_sync #(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rstn_i,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  // ==========================================================================
  // Two stages; only the second stage reads the first
  // ==========================================================================
  logic [WIDTH-1:0] meta_reg;  // First stage, may be metastable

  // Sample pins, then retime
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule

// ===== srh_mem_model.sv
// Behavioural asynchronous static memory facing the host controller
`timescale 1ns/1ns
module srh_mem_model #(
  parameter int unsigned ACC_NS = 6  // Read data delay, inside 16 ns
) (
  // Pins from the controller
  input  wire srh_pkg::srh_pins_t         pins_i,
  // Resolved data lines and contention flag
  output logic [srh_pkg::DQ_W-1:0]        dq_o,
  output logic                            clash_o
);
  // ==========================================================================
  // Storage and decode
  // ==========================================================================
  logic [15:0] mem [0:15];         // Small array, low address bits only
  logic [15:0] lane;               // Per-bit lane select
  logic [15:0] rd_drv;             // Bits the memory drives
  logic [15:0] rd_val;             // Word at the current address
  logic [15:0] drv;                // Bits driven by anyone
  logic [15:0] last_q = 16'h0000;  // Last driven level per bit
  logic        sel;                // Chip selected

  assign sel  = ~pins_i.cs_n;
  // Sixteen-bit organisation only, so lanes always decode
  assign lane = {{8{~pins_i.upper_byte_strobe_n}},
                 {8{~pins_i.lower_byte_strobe_n}}};

  // Store throughout the overlap of select, strobe and lane
  always @* begin
    if (sel && !pins_i.we_n) begin
      for (int i = 0; i < 16; i++) begin
        if (lane[i]) begin
          mem[pins_i.addr[3:0]][i] = pins_i.dq_oe[i] ? pins_i.dq[i]
                                                     : ~last_q[i];
        end
      end
    end
  end

  // Read mode only; a strobe low keeps the outputs quiet
  assign rd_drv = (sel && !pins_i.oe_n && pins_i.we_n) ? lane
                                                       : 16'h0000;
  assign rd_val = mem[pins_i.addr[3:0]];
  assign drv    = pins_i.dq_oe | rd_drv;
  // Released bits show the inverse, so a stale value never passes
  assign #(ACC_NS) dq_o = (pins_i.dq_oe & pins_i.dq)
                        | (~pins_i.dq_oe & rd_drv & rd_val)
                        | (~drv & ~last_q);
  assign clash_o = |(pins_i.dq_oe & rd_drv);

  // Remember only levels that somebody really drove
  always @(dq_o) begin
    last_q = (last_q & ~drv) | (dq_o & drv);
  end
endmodule

// ===== tb.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/1ns
module tb;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic               mclk = 1'b0;         // 125 MHz clock
  logic               rst_n = 1'b0;        // Reset, active low
  logic               req_valid = 1'b0;    // Request strobe
  srh_pkg::srh_req_t  req = '0;            // Request fields
  logic               req_ready;           // Controller idle
  logic               resp_valid;          // End of transfer
  logic [15:0]        rdata;               // Read word
  srh_pkg::srh_pins_t pins;                // Memory pins
  srh_pkg::srh_pins_t prev;                // Pins one cycle back
  logic [15:0]        dq;                  // Resolved data lines
  logic               clash;               // Both sides driving
  int                 err_count = 0;       // Mismatches
  int                 checks = 0;          // Comparisons made
  int                 wlow = 0;            // Strobe low cycles

  always #4 mclk = ~mclk;

  srh_ctrl #(.DATA_W(16)) srh_ctrl_i (
    .mclk_i(mclk), .rstn_i(rst_n), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_i(req), .resp_valid_o(resp_valid),
    .rdata_o(rdata), .pins_o(pins), .dq_i(dq));

  srh_mem_model #(.ACC_NS(6)) srh_mem_model_i (
    .pins_i(pins), .dq_o(dq), .clash_o(clash));

  // ==========================================================================
  // Compare and closing tasks
  // ==========================================================================
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic tally_and_finish();
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Pin watcher, every cycle out of reset
  // ==========================================================================
  always @(posedge mclk) begin
    prev <= pins;
    if (rst_n) begin
      if (!pins.cs_n && !pins.oe_n) cmp_bit(pins.we_n, 1'b1);
      if (!pins.cs_n && !pins.oe_n) cmp_val(pins.dq_oe, 32'h0);
      cmp_bit(clash, 1'b0);
      if (!pins.we_n) cmp_bit(prev.cs_n, 1'b0);
      if (!pins.cs_n && !prev.cs_n) cmp_val(pins.addr, prev.addr);
      if (pins.we_n && !prev.we_n) cmp_val(pins.addr, prev.addr);
      if (pins.we_n && !prev.we_n) cmp_val(wlow, srh_pkg::WP_CYC);
      wlow <= pins.we_n ? 0 : wlow + 1;
    end
  end

  // ==========================================================================
  // One request, taken and answered under bounded waits
  // ==========================================================================
  task automatic xfer(input logic we, input logic [21:0] a,
                      input logic [15:0] d, input logic [1:0] be,
                      output logic [15:0] rd);
    int n;
    @(posedge mclk);
    req       <= '{we: we, addr: a, wdata: d, be: be};
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    // Request never taken: count it and close the run
    if (req_ready !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (resp_valid !== 1'b1 && n < 50);
    // No answer within the bound: count it and close the run
    if (resp_valid !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end else begin
      rd = rdata;
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Idle pins after reset leave the memory deselected
  task automatic t_reset();
    #1;
    cmp_val({pins.cs_n, pins.we_n, pins.oe_n}, 32'h7);
    cmp_val({pins.upper_byte_strobe_n, pins.lower_byte_strobe_n},
            32'h3);
    cmp_val(pins.dq_oe, 32'h0);
    cmp_bit(req_ready, 1'b1);
  endtask

  // Full word written and read back
  task automatic t_full();
    logic [15:0] rd;
    xfer(1'b1, 22'h000003, 16'ha5c3, 2'h3, rd);
    xfer(1'b0, 22'h000003, 16'h0000, 2'h3, rd);
    cmp_val(rd, 32'ha5c3);
  endtask

  // Lane writes merge; no lane means no store
  task automatic t_lanes();
    logic [15:0] rd;
    xfer(1'b1, 22'h000005, 16'h1111, 2'h3, rd);
    xfer(1'b1, 22'h000005, 16'haaaa, 2'h1, rd);
    xfer(1'b1, 22'h000005, 16'hbbbb, 2'h2, rd);
    xfer(1'b1, 22'h000005, 16'hcccc, 2'h0, rd);
    xfer(1'b0, 22'h000005, 16'h0000, 2'h3, rd);
    cmp_val(rd, 32'hbbaa);
    xfer(1'b0, 22'h000005, 16'h0000, 2'h1, rd);
    cmp_val(rd[7:0], 32'haa);
    xfer(1'b0, 22'h000005, 16'h0000, 2'h2, rd);
    cmp_val(rd[15:8], 32'hbb);
  endtask

  // Back-to-back writes and reads at changing addresses
  task automatic t_b2b();
    logic [15:0] rd;
    xfer(1'b1, 22'h000007, 16'h7e71, 2'h3, rd);
    xfer(1'b1, 22'h000008, 16'h8d82, 2'h3, rd);
    xfer(1'b0, 22'h000007, 16'h0000, 2'h3, rd);
    cmp_val(rd, 32'h7e71);
    xfer(1'b0, 22'h000008, 16'h0000, 2'h3, rd);
    cmp_val(rd, 32'h8d82);
    xfer(1'b0, 22'h000003, 16'h0000, 2'h3, rd);
    cmp_val(rd, 32'ha5c3);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_full();
    t_lanes();
    t_b2b();
    repeat (4) @(posedge mclk);
    tally_and_finish();
  end
endmodule
